// ===== logic/mmtwi_pkg.sv
// Shared constants and types of the multi-master two-wire bus interface.
// Assumes one 25 MHz system clock that also serves as the oscillator clock.
package mmtwi_pkg;

	// ------------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------------
	localparam logic [7:0] ADDR_BUS_CONTROL = 8'hf0;
	localparam logic [7:0] ADDR_STATUS      = 8'hf1;
	localparam logic [7:0] ADDR_SHIFT       = 8'hf2;
	localparam logic [7:0] ADDR_OWN         = 8'hf3;

	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	localparam int CTL_ACK_EN   = 7;
	localparam int CTL_CLK_SEL  = 6;
	localparam int CTL_IRQ_EN   = 5;
	localparam int CTL_PEND     = 4;
	localparam int CTL_PRESC_HI = 3;
	localparam int ST_MASTER    = 7;
	localparam int ST_TX        = 6;
	localparam int ST_BUSY      = 5;
	localparam int ST_OE        = 4;
	localparam int OWN_ADDR_LO  = 1;

	// ------------------------------------------------------------------
	// Reset values and timing
	// ------------------------------------------------------------------
	localparam logic [7:0]  CTL_RESET    = 8'h00;
	localparam logic [7:0]  OWN_RESET    = 8'h00;
	localparam int          SRC_DIV_FAST = 16;
	localparam int          SRC_DIV_SLOW = 512;
	localparam logic [12:0] HALF_FAST    = 13'(SRC_DIV_FAST / 2);
	localparam logic [12:0] HALF_SLOW    = 13'(SRC_DIV_SLOW / 2);
	localparam logic [3:0]  FREE_CYCLES  = 4'h4;
	localparam logic [3:0]  BITS_BYTE    = 4'h8;
	localparam logic [3:0]  BIT_ACK      = 4'h9;

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		M_IDLE,
		M_RUN,
		M_RESTART,
		M_STOP
	} mmtwi_mphase_e;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       we;
		logic       re;
	} mmtwi_req_s;

	typedef struct packed {
		logic scl;
		logic sda;
	} mmtwi_pin_in_s;

	typedef struct packed {
		logic scl_out;
		logic scl_oe;
		logic sda_out;
		logic sda_oe;
	} mmtwi_pin_out_s;

	typedef struct packed {
		logic [7:0]     ctl;
		logic [7:0]     own;
		logic [7:0]     shift;
		logic [7:0]     rdata;
		logic           ms;
		logic           tx;
		logic           oe_en;
		logic           busy;
		logic           arb;
		logic           match;
		logic           gc;
		logic           last;
		logic           scl_s1;
		logic           scl_s2;
		logic           scl_d;
		logic           sda_s1;
		logic           sda_s2;
		logic           sda_d;
		mmtwi_pin_out_s pins;
		logic [3:0]     bitcnt;
		logic           addr_ph;
		logic           active;
		logic           hold;
		logic           start_req;
		logic           stop_req;
		mmtwi_mphase_e  mph;
		logic [12:0]    tcnt;
		logic [3:0]     free_cnt;
		logic           freeing;
		logic           irq;
	} mmtwi_state_s;

endpackage : mmtwi_pkg

// ===== logic/mmtwi_top.sv
// Multi-master two-wire bus interface: master/slave, transmit/receive.
// Assumes open-drain pins resolved outside and a one-cycle register port.
module mmtwi_top (
	// Clock and reset
	input  wire logic                      clk,
	input  wire logic                      rstn,
	// Register port
	input  wire mmtwi_pkg::mmtwi_req_s     bus,
	output logic [7:0]                     rdata,
	// Bus pins
	input  wire mmtwi_pkg::mmtwi_pin_in_s  pin_in,
	output mmtwi_pkg::mmtwi_pin_out_s      pin_out,
	// Transfer request
	output logic                           xfer_irq
);
	import mmtwi_pkg::*;

	// ------------------------------------------------------------------
	// State and decoded events
	// ------------------------------------------------------------------
	mmtwi_state_s s;
	mmtwi_state_s next_s;

	logic        rise;
	logic        fall;
	logic        start_det;
	logic        stop_det;
	logic [12:0] half_m1;
	logic [7:0]  status_byte;
	logic        addr_hit;
	logic        gen_call;

	assign rise      = s.scl_s2 & ~s.scl_d;
	assign fall      = ~s.scl_s2 & s.scl_d;
	assign start_det = s.scl_s2 & s.scl_d & s.sda_d & ~s.sda_s2;
	assign stop_det  = s.scl_s2 & s.scl_d & ~s.sda_d & s.sda_s2;
	assign gen_call  = (s.shift[7:OWN_ADDR_LO] == 7'h00);
	assign addr_hit  = (s.shift[7:OWN_ADDR_LO] == s.own[7:OWN_ADDR_LO]) | gen_call;

	// Half SCL period in system clocks, less one
	assign half_m1 = 13'((s.ctl[CTL_CLK_SEL] ? HALF_SLOW : HALF_FAST)
		* ({9'h000, s.ctl[CTL_PRESC_HI:0]} + 13'h0001) - 13'h0001);

	assign status_byte = {s.ms, s.tx, s.busy, s.oe_en, s.arb, s.match, s.gc, s.last};

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		logic set_pend;
		logic release_hold;
		logic tmr_run;
		set_pend     = 1'b0;
		release_hold = 1'b0;
		tmr_run      = 1'b0;
		next_s       = s;

		// Pin synchronisers
		next_s.scl_s1 = pin_in.scl;
		next_s.scl_s2 = s.scl_s1;
		next_s.scl_d  = s.scl_s2;
		next_s.sda_s1 = pin_in.sda;
		next_s.sda_s2 = s.sda_s1;
		next_s.sda_d  = s.sda_s2;

		// Register reads
		next_s.rdata = 8'h00;
		if (bus.re) begin
			if (bus.addr == ADDR_BUS_CONTROL) begin
				next_s.rdata = s.ctl;
			end else if (bus.addr == ADDR_STATUS) begin
				next_s.rdata = status_byte;
			end else if (bus.addr == ADDR_SHIFT) begin
				next_s.rdata = s.shift;
				if (s.hold && !s.tx) begin
					release_hold = 1'b1;
				end
			end else if (bus.addr == ADDR_OWN) begin
				next_s.rdata = s.own;
			end
		end

		// Register writes
		if (bus.we) begin
			if (bus.addr == ADDR_BUS_CONTROL) begin
				next_s.ctl = {bus.wdata[7:5], s.ctl[CTL_PEND] & bus.wdata[CTL_PEND],
					bus.wdata[3:0]};
			end else if (bus.addr == ADDR_STATUS) begin
				next_s.ms    = bus.wdata[ST_MASTER];
				next_s.tx    = bus.wdata[ST_TX];
				next_s.oe_en = bus.wdata[ST_OE];
				if (bus.wdata[ST_MASTER] && bus.wdata[ST_BUSY]) begin
					next_s.start_req = 1'b1;
				end else if (bus.wdata[ST_MASTER] && s.busy && s.ms) begin
					next_s.stop_req = 1'b1;
				end
				// Flags in bits 3..0 ignore the write
			end else if (bus.addr == ADDR_SHIFT) begin
				if (s.oe_en) begin
					next_s.shift = bus.wdata;
					if (s.hold) begin
						release_hold = 1'b1;
						if (s.tx) begin
							next_s.pins.sda_oe = ~bus.wdata[7];
						end
					end
				end
			end else if (bus.addr == ADDR_OWN) begin
				next_s.own = {bus.wdata[7:OWN_ADDR_LO], 1'b0};
			end
		end

		// Stretch release
		if (release_hold) begin
			next_s.hold = 1'b0;
			next_s.tcnt = 13'h0000;
			if (!s.ms) begin
				next_s.pins.scl_oe = 1'b0;
			end
		end

		// Master stop or repeated start out of a stretched slot
		if (s.hold && s.ms && s.stop_req) begin
			next_s.hold        = 1'b0;
			next_s.stop_req    = 1'b0;
			next_s.pins.sda_oe = 1'b1;
			next_s.mph         = M_STOP;
			next_s.tcnt        = 13'h0000;
		end else if (s.hold && s.ms && s.start_req) begin
			next_s.hold        = 1'b0;
			next_s.start_req   = 1'b0;
			next_s.pins.sda_oe = 1'b0;
			next_s.mph         = M_RESTART;
			next_s.tcnt        = 13'h0000;
		end

		// Start from a free bus
		if (s.start_req && s.ms && !s.busy && !start_det) begin
			next_s.pins.sda_oe = 1'b1;
			next_s.mph         = M_RUN;
		end

		// Bus free delay
		if (s.freeing) begin
			if (s.free_cnt == 4'h0) begin
				next_s.busy    = 1'b0;
				next_s.freeing = 1'b0;
			end else begin
				next_s.free_cnt = s.free_cnt - 4'h1;
			end
		end

		// ------------------------------------------------------------------
		// Bit engine
		// ------------------------------------------------------------------
		if (stop_det) begin
			next_s.freeing     = 1'b1;
			next_s.free_cnt    = FREE_CYCLES;
			next_s.active      = 1'b0;
			next_s.hold        = 1'b0;
			next_s.ms          = 1'b0;
			next_s.stop_req    = 1'b0;
			next_s.mph         = M_IDLE;
			next_s.pins.scl_oe = 1'b0;
			next_s.pins.sda_oe = 1'b0;
		end else if (start_det) begin
			next_s.busy      = 1'b1;
			next_s.freeing   = 1'b0;
			next_s.bitcnt    = 4'h0;
			next_s.addr_ph   = 1'b1;
			next_s.active    = 1'b1;
			next_s.hold      = 1'b0;
			next_s.arb       = 1'b0;
			next_s.match     = 1'b0;
			next_s.gc        = 1'b0;
			next_s.start_req = 1'b0;
			next_s.tcnt      = 13'h0000;
			next_s.tx        = s.ms;
			next_s.mph       = s.ms ? M_RUN : M_IDLE;
			if (!s.ms) begin
				next_s.pins.scl_oe = 1'b0;
				next_s.pins.sda_oe = 1'b0;
			end
		end else if (s.active && s.busy) begin
			if (rise) begin
				if (s.bitcnt < BITS_BYTE) begin
					next_s.shift  = {s.shift[6:0], s.sda_s2};
					next_s.bitcnt = s.bitcnt + 4'h1;
					if (s.ms && s.tx && !s.pins.sda_oe && !s.sda_s2) begin
						next_s.arb         = 1'b1;
						next_s.ms          = 1'b0;
						next_s.tx          = 1'b0;
						next_s.mph         = M_IDLE;
						next_s.pins.scl_oe = 1'b0;
						next_s.active      = s.addr_ph;
						set_pend           = 1'b1;
					end
				end else if (s.bitcnt == BITS_BYTE) begin
					next_s.last   = s.sda_s2;
					next_s.bitcnt = BIT_ACK;
				end
			end
			if (fall) begin
				if (s.bitcnt < BITS_BYTE) begin
					if (s.tx) begin
						next_s.pins.sda_oe = ~s.shift[7];
					end
				end else if (s.bitcnt == BITS_BYTE) begin
					if (s.addr_ph && !s.ms) begin
						if (addr_hit) begin
							next_s.match       = 1'b1;
							next_s.gc          = gen_call;
							next_s.tx          = s.shift[0];
							next_s.pins.sda_oe = s.ctl[CTL_ACK_EN];
						end else begin
							next_s.active      = 1'b0;
							next_s.pins.sda_oe = 1'b0;
						end
					end else if (s.addr_ph) begin
						next_s.tx          = ~s.shift[0];
						next_s.pins.sda_oe = 1'b0;
					end else begin
						next_s.pins.sda_oe = s.tx ? 1'b0 : s.ctl[CTL_ACK_EN];
					end
				end else begin
					next_s.bitcnt      = 4'h0;
					next_s.addr_ph     = 1'b0;
					next_s.pins.sda_oe = 1'b0;
					set_pend           = 1'b1;
					if (!s.ms && s.tx && s.last) begin
						next_s.active = 1'b0;
					end else begin
						next_s.hold        = 1'b1;
						next_s.pins.scl_oe = 1'b1;
					end
				end
			end
		end

		// ------------------------------------------------------------------
		// Master SCL generator
		// ------------------------------------------------------------------
		tmr_run = s.ms && s.busy && !s.hold && (s.mph != M_IDLE)
			&& (s.pins.scl_oe || s.scl_s2);
		if (tmr_run && !start_det && !stop_det) begin
			if (s.tcnt >= half_m1) begin
				next_s.tcnt = 13'h0000;
				if (s.pins.scl_oe) begin
					next_s.pins.scl_oe = 1'b0;
				end else begin
					case (s.mph)
						M_STOP: begin
							next_s.pins.sda_oe = 1'b0;
						end
						M_RESTART: begin
							next_s.pins.sda_oe = 1'b1;
						end
						default: begin
							next_s.pins.scl_oe = 1'b1;
						end
					endcase
				end
			end else begin
				next_s.tcnt = s.tcnt + 13'h0001;
			end
		end else if (!start_det) begin
			next_s.tcnt = 13'h0000;
		end

		// Pending flag: a set wins over a software clear
		if (set_pend) begin
			next_s.ctl[CTL_PEND] = 1'b1;
		end
		next_s.irq = next_s.ctl[CTL_IRQ_EN] & next_s.ctl[CTL_PEND];

		// Synchronous reset
		if (!rstn) begin
			next_s        = '0;
			next_s.ctl    = CTL_RESET;
			next_s.own    = OWN_RESET;
			next_s.mph    = M_IDLE;
			next_s.scl_s1 = 1'b1;
			next_s.scl_s2 = 1'b1;
			next_s.scl_d  = 1'b1;
			next_s.sda_s1 = 1'b1;
			next_s.sda_s2 = 1'b1;
			next_s.sda_d  = 1'b1;
		end
	end

	// ------------------------------------------------------------------
	// State register and outputs
	// ------------------------------------------------------------------
	always_ff @(posedge clk) begin
		s <= next_s;
	end

	assign rdata    = s.rdata;
	assign pin_out  = s.pins;
	assign xfer_irq = s.irq;

endmodule : mmtwi_top

// ===== testbench/mmtwi_chk_sva.sv
// Port checker of the two-wire bus interface.
// Assumes the register port idles between strobes.
module mmtwi_chk (
	// Clock and reset
	input wire logic                      clk,
	input wire logic                      rstn,
	// Register port
	input wire mmtwi_pkg::mmtwi_req_s     bus,
	input wire logic [7:0]                rdata,
	// Bus pins
	input wire mmtwi_pkg::mmtwi_pin_in_s  pin_in,
	input wire mmtwi_pkg::mmtwi_pin_out_s pin_out,
	// Transfer request
	input wire logic                      xfer_irq
);
	timeunit 1ns;
	timeprecision 1ps;
	import mmtwi_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	// ----
	// Register steps
	// ----
	sequence own_wr; bus.we && bus.addr == ADDR_OWN; endsequence
	sequence own_rd; bus.re && bus.addr == ADDR_OWN; endsequence
	sequence ctl_wr; bus.we && bus.addr == ADDR_BUS_CONTROL; endsequence
	sequence ctl_rd; bus.re && bus.addr == ADDR_BUS_CONTROL; endsequence
	rd_idle_a: assert property (!bus.re |=> rdata == 8'h00)
		else $error("read data outside answer");
	unmapped_a: assert property (bus.re && bus.addr[7:2] != 6'h3c |=> rdata == 8'h00)
		else $error("unmapped read not zero");
	own_bit0_a: assert property (own_rd |=> !rdata[0])
		else $error("own address bit0 set");
	own_back_a: assert property (own_wr ##1 !bus.we ##1 own_rd |=>
		rdata == ($past(bus.wdata, 3) & 8'hfe)) else $error("own address readback");
	ctl_back_a: assert property (ctl_wr ##1 !bus.we ##1 ctl_rd |=>
		(rdata & 8'hef) == ($past(bus.wdata, 3) & 8'hef)) else $error("control readback");
	irq_off_a: assert property (bus.we && bus.addr == ADDR_BUS_CONTROL &&
		!bus.wdata[CTL_IRQ_EN] ##1 !bus.we |=> !xfer_irq) else $error("request not masked");
	pins_od_a: assert property (!pin_out.scl_out && !pin_out.sda_out)
		else $error("pin driven high");
	scl_high_a: assert property ($fell(pin_out.scl_oe) |-> !pin_out.scl_oe [*8])
		else $error("clock high too short");
endmodule : mmtwi_chk

bind mmtwi_top mmtwi_chk u_chk (.clk(clk), .rstn(rstn), .bus(bus), .rdata(rdata),
	.pin_in(pin_in), .pin_out(pin_out), .xfer_irq(xfer_irq));

// ===== testbench/mmtwi_far_slave.sv
// Far-side slave: acknowledges one address, takes and gives bytes.
// Assumes pulled-up lines and a clock far faster than the bus.
module mmtwi_far_slave #(
	parameter logic [6:0] ADDR = 7'h2a
) (
	// Clock
	input  wire logic       clk,
	// Bus lines
	input  wire logic       scl,
	input  wire logic       sda,
	output logic            scl_oe,
	output logic            sda_oe,
	// Bench side
	input  wire logic [7:0] tx_byte,
	input  wire logic       slow,
	output logic [7:0]      rx_byte,
	output logic [7:0]      nbytes
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       scl_d, sda_d, sel, rd, adr;
	logic [3:0] bitn;
	logic [7:0] sh;
	logic [5:0] cnt;
	initial begin
		{scl_d, sda_d, sel, rd, adr, scl_oe, sda_oe} = 7'b1100000;
		{bitn, sh, cnt, rx_byte, nbytes} = '0;
	end
	// ----
	// Bus follower
	// ----
	always @(posedge clk) begin
		scl_d <= scl;
		sda_d <= sda;
		if (scl_oe) begin
			cnt <= cnt + 6'h01;
			if (cnt == 6'h3f) scl_oe <= 1'b0;
		end
		if (scl && scl_d && sda_d && !sda) begin
			bitn <= 4'hf;
			adr <= 1'b1;
			sel <= 1'b0;
			sda_oe <= 1'b0;
		end else if (scl && scl_d && !sda_d && sda) begin
			sel <= 1'b0;
			sda_oe <= 1'b0;
		end else if (scl && !scl_d) begin
			if (bitn < 4'h8) sh <= {sh[6:0], sda};
			else if (rd && sda) sel <= 1'b0;
		end else if (!scl && scl_d) begin
			bitn <= (bitn == 4'h8) ? 4'h0 : bitn + 4'h1;
			if (bitn == 4'h7 && adr) begin
				adr <= 1'b0;
				sel <= sh[7:1] == ADDR;
				rd <= sh[0];
				sda_oe <= sh[7:1] == ADDR;
			end else if (bitn == 4'h7) begin
				sda_oe <= sel && !rd;
				if (sel && !rd) rx_byte <= sh;
				if (sel && !rd) nbytes <= nbytes + 8'h01;
			end else if (bitn == 4'h8) begin
				sda_oe <= sel && rd && !tx_byte[7];
				scl_oe <= slow;
				cnt <= 6'h00;
			end else sda_oe <= sel && rd && !tx_byte[3'(6 - bitn)];
		end
	end
endmodule : mmtwi_far_slave

// ===== testbench/tb.sv
// Testbench of the two-wire bus interface: registers, write, abort, read.
// Assumes the far slave model and the bound checker.
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import mmtwi_pkg::*;
	localparam logic [6:0] SLV = 7'h2a;
	logic           clk, rstn, scl, sda, slow, xfer_irq, s_scl_oe, s_sda_oe;
	logic [7:0]     rdata, tx_byte, rx_byte, nbytes, d, v;
	logic [15:0]    lfsr;
	mmtwi_req_s     bus;
	mmtwi_pin_out_s pin_out;
	mmtwi_pin_in_s  pin_in;
	int             num_errors, samples_checked;
	assign scl = !(pin_out.scl_oe | s_scl_oe);
	assign sda = !(pin_out.sda_oe | s_sda_oe);
	assign pin_in = '{scl: scl, sda: sda};
	mmtwi_top u_dut (.clk(clk), .rstn(rstn), .bus(bus), .rdata(rdata),
		.pin_in(pin_in), .pin_out(pin_out), .xfer_irq(xfer_irq));
	mmtwi_far_slave #(.ADDR(SLV)) u_slave (.clk(clk), .scl(scl), .sda(sda), .scl_oe(s_scl_oe),
		.sda_oe(s_sda_oe), .tx_byte(tx_byte), .slow(slow), .rx_byte(rx_byte), .nbytes(nbytes));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// ----
	// Tasks
	// ----
	function automatic logic [7:0] rnd();
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		return lfsr[7:0];
	endfunction : rnd
	task automatic wr(logic [7:0] a, logic [7:0] w);
		@(posedge clk);
		bus <= '{addr: a, wdata: w, we: 1'b1, re: 1'b0};
		@(posedge clk);
		bus <= '{addr: a, wdata: w, we: 1'b0, re: 1'b0};
	endtask : wr
	task automatic rd(logic [7:0] a, output logic [7:0] r);
		@(posedge clk);
		bus <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
		@(posedge clk);
		bus <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b0};
		#1;
		r = rdata;
	endtask : rd
	task automatic test_done;
		if (num_errors == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : test_done
	task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic rd_chk(string name, logic [7:0] a, logic [7:0] m, logic [7:0] exp);
		rd(a, d);
		check(name, d & m, exp);
	endtask : rd_chk
	task automatic wait_irq;
		int n;
		n = 0;
		while (xfer_irq !== 1'b1 && n < 4000) begin
			@(posedge clk);
			n++;
		end
		if (n == 4000) check("irq_wait", 8'h00, 8'h01);
		if (n == 4000) test_done;
	endtask : wait_irq
	task automatic stop_free(logic [7:0] st, logic [7:0] ctl);
		int n;
		n = 0;
		wr(ADDR_STATUS, st);
		wr(ADDR_BUS_CONTROL, ctl);
		d = 8'hff;
		while (d[ST_BUSY] !== 1'b0 && n < 200) begin
			rd(ADDR_STATUS, d);
			n++;
		end
		check("busy", d & 8'h20, 8'h00);
		if (n == 200) test_done;
	endtask : stop_free
	// ----
	// Sequence
	// ----
	initial begin
		bus = '0;
		rstn = 1'b0;
		{tx_byte, slow, num_errors, samples_checked} = '0;
		lfsr = 16'd51456;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		for (int i = 0; i < 4; i++) rd_chk("reset", 8'hf0 + 8'(i), 8'hff, 8'h00);
		wr(ADDR_SHIFT, 8'h5a);
		rd_chk("shift_locked", ADDR_SHIFT, 8'hff, 8'h00);
		wr(ADDR_STATUS, 8'h1f);
		rd_chk("status_ro", ADDR_STATUS, 8'hff, 8'h10);
		for (int i = 0; i < 8; i++) begin
			v = rnd();
			wr(ADDR_OWN, v);
			rd_chk("own", ADDR_OWN, 8'hff, v & 8'hfe);
			wr(ADDR_BUS_CONTROL, v & 8'hef);
			rd_chk("ctl", ADDR_BUS_CONTROL, 8'hef, v & 8'hef);
			rd_chk("unmapped", {2'b00, v[5:0]}, 8'hff, 8'h00);
		end
		wr(ADDR_OWN, 8'h10);
		wr(ADDR_BUS_CONTROL, 8'ha0);
		wr(ADDR_SHIFT, {SLV, 1'b0});
		wr(ADDR_STATUS, 8'hf0);
		wait_irq;
		rd_chk("addr_ack", ADDR_STATUS, 8'hf1, 8'hf0);
		wr(ADDR_BUS_CONTROL, 8'ha0);
		v = rnd();
		wr(ADDR_SHIFT, v);
		wait_irq;
		check("rx_byte", rx_byte, v);
		check("nbytes", nbytes, 8'h01);
		stop_free(8'hd0, 8'ha0);
		wr(ADDR_SHIFT, {SLV ^ 7'h01, 1'b0});
		wr(ADDR_STATUS, 8'hf0);
		wait_irq;
		rd_chk("addr_nack", ADDR_STATUS, 8'h01, 8'h01);
		stop_free(8'hd0, 8'ha0);
		v = rnd();
		tx_byte <= v;
		slow <= 1'b1;
		wr(ADDR_BUS_CONTROL, 8'h20);
		wr(ADDR_SHIFT, {SLV, 1'b1});
		wr(ADDR_STATUS, 8'hf0);
		wait_irq;
		rd_chk("rx_mode", ADDR_STATUS, 8'hc1, 8'h80);
		wr(ADDR_BUS_CONTROL, 8'h20);
		rd(ADDR_SHIFT, d);
		wait_irq;
		rd_chk("rx_data", ADDR_SHIFT, 8'hff, v);
		rd_chk("nack", ADDR_STATUS, 8'h01, 8'h01);
		stop_free(8'h90, 8'h20);
		test_done;
	end
endmodule : tb
